// ===== rtl/io_port_pkg.sv
// Shared constants, types and register map of the I/O port bank
package io_port_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int NUM_PORTS = 6;
	localparam int ADDR_W    = 5;
	localparam int DATA_W    = 8;
	localparam int NUM_IRQ   = 4;
	localparam int NUM_PU    = 3;

	typedef logic [DATA_W-1:0] port_byte_t;
	typedef logic [ADDR_W-1:0] reg_addr_t;

	// Port slot indices (ports 0,1,3,4,5,6)
	localparam int IDX_P0 = 0;
	localparam int IDX_P1 = 1;
	localparam int IDX_P3 = 2;
	localparam int IDX_P4 = 3;
	localparam int IDX_P5 = 4;
	localparam int IDX_P6 = 5;

	// ----------------------------------------------------------------
	// Per-port bit masks, slot 5 first
	// ----------------------------------------------------------------
	localparam port_byte_t [NUM_PORTS-1:0] PORT_MASK =
		{8'hff, 8'h13, 8'hff, 8'h0f, 8'h2f, 8'hff};
	localparam port_byte_t [NUM_PORTS-1:0] ALT_MASK =
		{8'hff, 8'h13, 8'hfc, 8'h0e, 8'h2f, 8'h00};
	// Alternate functions that drive the pin
	localparam port_byte_t [NUM_PORTS-1:0] ALT_OUT_MASK =
		{8'h00, 8'h10, 8'h90, 8'h08, 8'h08, 8'h00};
	// Alternate functions that only sample the pin
	localparam port_byte_t [NUM_PORTS-1:0] ALT_IN_MASK =
		{8'hff, 8'h03, 8'h68, 8'h06, 8'h27, 8'h00};
	localparam port_byte_t [NUM_PORTS-1:0] ANALOG_MASK =
		{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// ----------------------------------------------------------------
	// Alternate function bit positions
	// ----------------------------------------------------------------
	localparam int P1_IRQ0_BIT = 0;
	localparam int P1_IRQ1_BIT = 1;
	localparam int P1_IRQ2_BIT = 2;
	localparam int P1_BUZ_BIT  = 3;
	localparam int P1_EC0_BIT  = 5;
	localparam int P3_ACLK_BIT = 1;
	localparam int P3_RX_BIT   = 2;
	localparam int P3_TX_BIT   = 3;
	localparam int P4_SCK_BIT  = 2;
	localparam int P4_SI_BIT   = 3;
	localparam int P4_SO_BIT   = 4;
	localparam int P4_ACLK_BIT = 5;
	localparam int P4_RX_BIT   = 6;
	localparam int P4_TX_BIT   = 7;
	localparam int P5_IRQ3_BIT = 0;
	localparam int P5_EC1_BIT  = 1;
	localparam int P5_T3_BIT   = 4;
	localparam int MISC_T3_SEL_BIT = 0;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam reg_addr_t ADDR_DATA_BASE = 5'h00;
	localparam reg_addr_t ADDR_DIR_BASE  = 5'h06;
	localparam reg_addr_t ADDR_PU_BASE   = 5'h0c;
	localparam reg_addr_t ADDR_ALT_BASE  = 5'h0f;
	localparam reg_addr_t ADDR_IRQ_EDGE  = 5'h15;
	localparam reg_addr_t ADDR_MISC      = 5'h16;
	localparam port_byte_t RESET_BYTE    = 8'h00;
	localparam port_byte_t MISC_MASK     = 8'h01;

	// Pull-up slots map to ports 0, 1 and 4
	localparam int PU_SLOT_P0 = 0;
	localparam int PU_SLOT_P1 = 1;
	localparam int PU_SLOT_P4 = 2;

	typedef enum logic [1:0] {
		EDGE_OFF  = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_FALL = 2'h2,
		EDGE_BOTH = 2'h3
	} edge_sel_t;

	// Pin drive bundle, one per port
	typedef struct packed {
		port_byte_t level;
		port_byte_t oe_n;
	} pin_drive_t;

endpackage

// ===== rtl/irq_edge_detect.sv
// Edge detector for the external interrupt request lines
`timescale 1ns/1ps
module irq_edge_detect #(
	parameter int N = 4
) (
	// Clock and reset
	input  wire logic                         clock_i,
	input  wire logic                         srst_i,
	// Synchronised levels and configuration
	input  wire logic [N-1:0]                 level_i,
	input  wire logic [N-1:0]                 enable_i,
	input  wire io_port_pkg::edge_sel_t [N-1:0] mode_i,
	// Request pulses
	output logic [N-1:0]                      pulse_o
);
	import io_port_pkg::*;

	logic [N-1:0] prev_reg;
	logic         armed_reg;
	logic [N-1:0] pulse_reg;
	logic [N-1:0] pulse_next;

	// First cycle after reset only captures the level, so a level_i that is
	// already high does not look like a rising edge (a bank pin high through reset still does: its synchroniser resets to 0)
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			prev_reg  <= '0;
			armed_reg <= 1'b0;
		end else begin
			prev_reg  <= level_i;
			armed_reg <= 1'b1;
		end
	end

	always_comb begin
		for (int i = 0; i < N; i++) begin
			case (mode_i[i])
				EDGE_RISE: pulse_next[i] = level_i[i] & ~prev_reg[i];  // R5
				EDGE_FALL: pulse_next[i] = ~level_i[i] & prev_reg[i];  // R5
				EDGE_BOTH: pulse_next[i] = level_i[i] ^ prev_reg[i];   // R5
				default:   pulse_next[i] = 1'b0;
			endcase
			pulse_next[i] = pulse_next[i] & enable_i[i] & armed_reg;
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			pulse_reg <= '0;
		end else begin
			pulse_reg <= pulse_next;
		end
	end

	assign pulse_o = pulse_reg;

endmodule

// ===== rtl/mcu_io_port_bank.sv
// General-purpose I/O port bank with alternate function muxing
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

// Function
// [R1] A pin drives its latch value when its direction bit is 1 and is an input when it is 0.
// [R2] Direction is chosen bit by bit, independently for each pin.
// [R3] Ports 0, 1 and 4 each have a pull-up selection register; ports 3, 5 and 6 have none.
// [R4] Ports 0, 4 and 6 are 8 bits, port 1 is 5 bits, port 3 is 4 bits, port 5 has bits 0, 1, 4.
// [R5] Each of the four external interrupt inputs triggers on rising, falling or both edges.
// [R6] Port 1 carries interrupt inputs 0 to 2, the buzzer output and the timer 0 event input.
// [R7] Port 3 bits 1 to 3 carry the second serial channel clock in, receive in and transmit out.
// [R8] Port 4 carries the synchronous serial clock, data in, data out and the first channel.
// [R9] Port 5 carries interrupt input 3, the timer 2 event input and the timer 3 output.
// [R10] All port 6 pins can be handed to the converter as analog channels 0 to 7.
// [R11] The synchronous serial clock pin drives when the interface makes the clock, else listens.
// [R12] After reset every pin is an input with direction and pull-up bits cleared.
// [R13] An active peripheral output drives its shared pin in place of the port latch.
module mcu_io_port_bank (
	// Clock and reset
	input  wire logic                                            clock_i,
	input  wire logic                                            srst_i,
	// Register port
	input  wire io_port_pkg::reg_addr_t                          addr_i,
	input  wire io_port_pkg::port_byte_t                         wdata_i,
	input  wire logic                                            wr_i,
	input  wire logic                                            rd_i,
	output io_port_pkg::port_byte_t                              rdata_o,
	// Pins, slots 0..5 = ports 0,1,3,4,5,6
	input  wire io_port_pkg::port_byte_t [io_port_pkg::NUM_PORTS-1:0] pin_in_i,
	output io_port_pkg::pin_drive_t [io_port_pkg::NUM_PORTS-1:0]      pin_drive_o,
	// Pull-up controls
	output io_port_pkg::port_byte_t                              port_zero_pullup_select_o,
	output io_port_pkg::port_byte_t                              port_one_pullup_select_o,
	output io_port_pkg::port_byte_t                              port_four_pullup_select_o,
	// Peripheral outputs toward pins
	input  wire logic                                            buzzer_out_i,
	input  wire logic                                            async_tx_first_i,
	input  wire logic                                            async_tx_second_i,
	input  wire logic                                            sio_data_out_i,
	input  wire logic                                            sio_clock_out_i,
	input  wire logic                                            sio_clock_drive_i,
	input  wire logic                                            timer_three_pulse_out_i,
	input  wire logic                                            timer_three_compare_out_i,
	// Pin values toward peripherals
	output logic [io_port_pkg::NUM_IRQ-1:0]                      ext_irq_req_o,
	output logic                                                 event_count_in_zero_o,
	output logic                                                 event_count_in_one_o,
	output logic                                                 async_clock_in_first_o,
	output logic                                                 async_rx_first_o,
	output logic                                                 async_clock_in_second_o,
	output logic                                                 async_rx_second_o,
	output logic                                                 sio_clock_in_o,
	output logic                                                 sio_data_in_o,
	output io_port_pkg::port_byte_t                              analog_in_channels_o
);
	import io_port_pkg::*;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic addr_hit(input reg_addr_t addr, input reg_addr_t base,
			input int count);
		reg_addr_t ofs;
		ofs = addr - base;
		return (addr >= base) && (int'(ofs) < count);
	endfunction

	function automatic logic [2:0] addr_slot(input reg_addr_t addr, input reg_addr_t base);
		reg_addr_t ofs;
		ofs = addr - base;
		return ofs[2:0];
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	port_byte_t [NUM_PORTS-1:0] data_reg;
	port_byte_t [NUM_PORTS-1:0] dir_reg;
	port_byte_t [NUM_PORTS-1:0] alt_reg;
	port_byte_t [NUM_PU-1:0]    pu_reg;
	port_byte_t                 edge_reg;
	port_byte_t                 misc_reg;
	port_byte_t                 rdata_reg;
	port_byte_t                 rdata_next;

	logic wr_data;
	logic wr_dir;
	logic wr_alt;
	logic wr_pu;

	assign wr_data = wr_i && addr_hit(addr_i, ADDR_DATA_BASE, NUM_PORTS);
	assign wr_dir  = wr_i && addr_hit(addr_i, ADDR_DIR_BASE, NUM_PORTS);
	assign wr_alt  = wr_i && addr_hit(addr_i, ADDR_ALT_BASE, NUM_PORTS);
	assign wr_pu   = wr_i && addr_hit(addr_i, ADDR_PU_BASE, NUM_PU);

	// Unimplemented bits are masked on write so they never drive
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			data_reg <= '0;
		end else if (wr_data) begin
			data_reg[addr_slot(addr_i, ADDR_DATA_BASE)] <=
				wdata_i & PORT_MASK[addr_slot(addr_i, ADDR_DATA_BASE)];  // R4
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			dir_reg <= '0;  // R12
		end else if (wr_dir) begin
			dir_reg[addr_slot(addr_i, ADDR_DIR_BASE)] <=
				wdata_i & PORT_MASK[addr_slot(addr_i, ADDR_DIR_BASE)];  // R2
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			pu_reg <= '0;  // R12
		end else if (wr_pu) begin
			pu_reg[addr_slot(addr_i, ADDR_PU_BASE)] <= wdata_i;  // R3
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			alt_reg <= '0;
		end else if (wr_alt) begin
			alt_reg[addr_slot(addr_i, ADDR_ALT_BASE)] <=
				wdata_i & ALT_MASK[addr_slot(addr_i, ADDR_ALT_BASE)];
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			edge_reg <= RESET_BYTE;
			misc_reg <= RESET_BYTE;
		end else if (wr_i && addr_i == ADDR_IRQ_EDGE) begin
			edge_reg <= wdata_i;  // R5
		end else if (wr_i && addr_i == ADDR_MISC) begin
			misc_reg <= wdata_i & MISC_MASK;
		end
	end

	assign port_zero_pullup_select_o = pu_reg[PU_SLOT_P0] & PORT_MASK[IDX_P0];  // R3
	assign port_one_pullup_select_o  = pu_reg[PU_SLOT_P1] & PORT_MASK[IDX_P1];  // R3
	assign port_four_pullup_select_o = pu_reg[PU_SLOT_P4] & PORT_MASK[IDX_P4];  // R3

	// ----------------------------------------------------------------
	// Pin input synchroniser
	// ----------------------------------------------------------------
	port_byte_t [NUM_PORTS-1:0] pin_meta_reg;
	port_byte_t [NUM_PORTS-1:0] pin_sync_reg;

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else begin
			pin_meta_reg <= pin_in_i;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	port_byte_t [NUM_PORTS-1:0] periph_level;
	port_byte_t [NUM_PORTS-1:0] out_oe;

	always_comb begin
		periph_level = '0;
		periph_level[IDX_P1][P1_BUZ_BIT] = buzzer_out_i;                  // R6
		periph_level[IDX_P3][P3_TX_BIT]  = async_tx_second_i;             // R7
		periph_level[IDX_P4][P4_SO_BIT]  = sio_data_out_i;                // R8
		periph_level[IDX_P4][P4_TX_BIT]  = async_tx_first_i;              // R8
		periph_level[IDX_P4][P4_SCK_BIT] = sio_clock_out_i;               // R11
		periph_level[IDX_P5][P5_T3_BIT]  = misc_reg[MISC_T3_SEL_BIT] ?
			timer_three_compare_out_i : timer_three_pulse_out_i;         // R9
	end

	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			out_oe[p] = dir_reg[p] & PORT_MASK[p];                        // R1
			// Input-only alternates and analog pins stay undriven
			out_oe[p] = out_oe[p] & ~(alt_reg[p] & ALT_IN_MASK[p]);      // R10
			out_oe[p] = out_oe[p] | (alt_reg[p] & ALT_OUT_MASK[p]);      // R13
		end
		// Clock pin direction follows whoever makes the clock
		if (alt_reg[IDX_P4][P4_SCK_BIT]) begin
			out_oe[IDX_P4][P4_SCK_BIT] = sio_clock_drive_i;               // R11
		end
	end

	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			pin_drive_o[p].oe_n  = ~out_oe[p];
			pin_drive_o[p].level = (data_reg[p] & ~alt_reg[p])
				| (periph_level[p] & alt_reg[p]);                         // R13
		end
	end

	// ----------------------------------------------------------------
	// Alternate inputs toward peripherals
	// ----------------------------------------------------------------
	assign event_count_in_zero_o   = pin_sync_reg[IDX_P1][P1_EC0_BIT];   // R6
	assign event_count_in_one_o    = pin_sync_reg[IDX_P5][P5_EC1_BIT];   // R9
	assign async_clock_in_second_o = pin_sync_reg[IDX_P3][P3_ACLK_BIT];  // R7
	assign async_rx_second_o       = pin_sync_reg[IDX_P3][P3_RX_BIT];    // R7
	assign sio_clock_in_o          = pin_sync_reg[IDX_P4][P4_SCK_BIT];   // R11
	assign sio_data_in_o           = pin_sync_reg[IDX_P4][P4_SI_BIT];    // R8
	assign async_clock_in_first_o  = pin_sync_reg[IDX_P4][P4_ACLK_BIT];  // R8
	assign async_rx_first_o        = pin_sync_reg[IDX_P4][P4_RX_BIT];    // R8
	assign analog_in_channels_o    = alt_reg[IDX_P6];                    // R10

	// ----------------------------------------------------------------
	// External interrupts
	// ----------------------------------------------------------------
	logic [NUM_IRQ-1:0]      irq_level;
	logic [NUM_IRQ-1:0]      irq_enable;
	edge_sel_t [NUM_IRQ-1:0] irq_mode;

	always_comb begin
		irq_level  = {pin_sync_reg[IDX_P5][P5_IRQ3_BIT], pin_sync_reg[IDX_P1][P1_IRQ2_BIT],
			pin_sync_reg[IDX_P1][P1_IRQ1_BIT], pin_sync_reg[IDX_P1][P1_IRQ0_BIT]};  // R6
		irq_enable = {alt_reg[IDX_P5][P5_IRQ3_BIT], alt_reg[IDX_P1][P1_IRQ2_BIT],
			alt_reg[IDX_P1][P1_IRQ1_BIT], alt_reg[IDX_P1][P1_IRQ0_BIT]};        // R9
		for (int i = 0; i < NUM_IRQ; i++) begin
			irq_mode[i] = edge_sel_t'(edge_reg[2*i +: 2]);
		end
	end

	irq_edge_detect #(
		.N (NUM_IRQ)
	) u_irq_edge (
		.clock_i  (clock_i),
		.srst_i   (srst_i),
		.level_i  (irq_level),
		.enable_i (irq_enable),
		.mode_i   (irq_mode),
		.pulse_o  (ext_irq_req_o)
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Output bits read back the latch, inputs read the pin; analog pins
	// read zero since their digital buffer is given over to the converter
	always_comb begin
		rdata_next = RESET_BYTE;
		if (addr_hit(addr_i, ADDR_DATA_BASE, NUM_PORTS)) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (addr_slot(addr_i, ADDR_DATA_BASE) == 3'(p)) begin
					rdata_next = ((data_reg[p] & dir_reg[p])
						| (pin_sync_reg[p] & ~dir_reg[p]))
						& PORT_MASK[p] & ~(alt_reg[p] & ANALOG_MASK[p]);
				end
			end
		end else if (addr_hit(addr_i, ADDR_DIR_BASE, NUM_PORTS)) begin
			rdata_next = dir_reg[addr_slot(addr_i, ADDR_DIR_BASE)];
		end else if (addr_hit(addr_i, ADDR_PU_BASE, NUM_PU)) begin
			rdata_next = pu_reg[addr_slot(addr_i, ADDR_PU_BASE)];
		end else if (addr_hit(addr_i, ADDR_ALT_BASE, NUM_PORTS)) begin
			rdata_next = alt_reg[addr_slot(addr_i, ADDR_ALT_BASE)];
		end else if (addr_i == ADDR_IRQ_EDGE) begin
			rdata_next = edge_reg;
		end else if (addr_i == ADDR_MISC) begin
			rdata_next = misc_reg;
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rdata_reg <= RESET_BYTE;
		end else begin
			rdata_reg <= rd_i ? rdata_next : RESET_BYTE;
		end
	end

	assign rdata_o = rdata_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_RESET_ALL_INPUT: assert property (@(posedge clock_i)  // R12
		$past(srst_i) |-> (pin_drive_o[IDX_P0].oe_n == 8'hff && pin_drive_o[IDX_P6].oe_n == 8'hff
			&& port_four_pullup_select_o == 8'h00))
		else $error("pins not all inputs after reset");

	AST_DIR_OUTPUT: assert property (@(posedge clock_i) disable iff (srst_i)  // R1
		(wr_i && addr_i == ADDR_DIR_BASE) |=> pin_drive_o[IDX_P0].oe_n == ~$past(wdata_i))
		else $error("port 0 direction not applied");

	AST_DIR_PER_BIT: assert property (@(posedge clock_i) disable iff (srst_i)  // R2
		(wr_i && addr_i == ADDR_DIR_BASE + 5'h05 && alt_reg[IDX_P6] == 8'h00 && !wr_alt)
		|=> pin_drive_o[IDX_P6].oe_n == ~$past(wdata_i))
		else $error("port 6 per-bit direction wrong");

	AST_PULLUP_WRITE: assert property (@(posedge clock_i) disable iff (srst_i)  // R3
		(wr_i && addr_i == ADDR_PU_BASE + 5'h01) |=>
			port_one_pullup_select_o == ($past(wdata_i) & PORT_MASK[IDX_P1]))
		else $error("port 1 pull-up select not applied");

	AST_NARROW_PORTS: assert property (@(posedge clock_i) disable iff (srst_i)  // R4
		(pin_drive_o[IDX_P1].oe_n | PORT_MASK[IDX_P1]) == 8'hff
		&& (pin_drive_o[IDX_P3].oe_n | PORT_MASK[IDX_P3]) == 8'hff
		&& (pin_drive_o[IDX_P5].oe_n | PORT_MASK[IDX_P5]) == 8'hff)
		else $error("unimplemented pin driven");

	AST_IRQ0_RISE: assert property (@(posedge clock_i) disable iff (srst_i)  // R5
		($rose(pin_sync_reg[IDX_P1][P1_IRQ0_BIT]) && !$past(srst_i) && irq_enable[0]
			&& irq_mode[0] == EDGE_RISE) |=> ext_irq_req_o[0])
		else $error("rising edge on interrupt 0 missed");

	AST_IRQ3_FALL: assert property (@(posedge clock_i) disable iff (srst_i)  // R9
		($fell(pin_sync_reg[IDX_P5][P5_IRQ3_BIT]) && !$past(srst_i) && irq_enable[3]
			&& irq_mode[3] != EDGE_RISE && irq_mode[3] != EDGE_OFF) |=> ext_irq_req_o[3])
		else $error("falling edge on interrupt 3 missed");

	AST_IRQ_NO_FALSE: assert property (@(posedge clock_i) disable iff (srst_i)  // R5
		(irq_mode[0] == EDGE_RISE && !$rose(pin_sync_reg[IDX_P1][P1_IRQ0_BIT]))
		|=> !ext_irq_req_o[0])
		else $error("interrupt 0 pulse without rising edge");

	AST_BUZZER_DRIVES: assert property (@(posedge clock_i) disable iff (srst_i)  // R13
		alt_reg[IDX_P1][P1_BUZ_BIT] |-> (!pin_drive_o[IDX_P1].oe_n[P1_BUZ_BIT]
			&& pin_drive_o[IDX_P1].level[P1_BUZ_BIT] == buzzer_out_i))
		else $error("buzzer not driving its pin");

	AST_TX_SECOND: assert property (@(posedge clock_i) disable iff (srst_i)  // R7
		alt_reg[IDX_P3][P3_TX_BIT] |-> pin_drive_o[IDX_P3].level[P3_TX_BIT] == async_tx_second_i)
		else $error("second transmit not on its pin");

	AST_SO_DRIVES: assert property (@(posedge clock_i) disable iff (srst_i)  // R8
		alt_reg[IDX_P4][P4_SO_BIT] |-> (!pin_drive_o[IDX_P4].oe_n[P4_SO_BIT]
			&& pin_drive_o[IDX_P4].level[P4_SO_BIT] == sio_data_out_i))
		else $error("serial data out not on its pin");

	AST_SCK_DIRECTION: assert property (@(posedge clock_i) disable iff (srst_i)  // R11
		alt_reg[IDX_P4][P4_SCK_BIT] |->
			pin_drive_o[IDX_P4].oe_n[P4_SCK_BIT] == !sio_clock_drive_i)
		else $error("serial clock pin direction wrong");

	AST_ANALOG_UNDRIVEN: assert property (@(posedge clock_i) disable iff (srst_i)  // R10
		(pin_drive_o[IDX_P6].oe_n | ~alt_reg[IDX_P6]) == 8'hff)
		else $error("analog pin driven");

endmodule

// ===== sim/io_board_model.sv
// Board-side model of the pins: bank drive, pull-ups and outside sources
`timescale 1ns/1ps
module io_board_model (
	// Drive from the bank
	input  wire io_port_pkg::pin_drive_t [io_port_pkg::NUM_PORTS-1:0] drive_i,
	input  wire io_port_pkg::port_byte_t                           pu0_i,
	input  wire io_port_pkg::port_byte_t                           pu1_i,
	input  wire io_port_pkg::port_byte_t                           pu4_i,
	// Outside sources, only seen where the bank is not driving
	input  wire io_port_pkg::port_byte_t [io_port_pkg::NUM_PORTS-1:0] ext_i,
	// Resolved pin levels
	output io_port_pkg::port_byte_t [io_port_pkg::NUM_PORTS-1:0]      pin_o
);
	import io_port_pkg::*;
	port_byte_t [NUM_PORTS-1:0] pu;
	// Outside sources only pull high, so a pull-up simply ORs in
	always_comb begin
		pu = '0;
		pu[IDX_P0] = pu0_i;
		pu[IDX_P1] = pu1_i;
		pu[IDX_P4] = pu4_i;
		for (int i = 0; i < NUM_PORTS; i++) begin
			pin_o[i] = (drive_i[i].level & ~drive_i[i].oe_n) | ((ext_i[i] | pu[i]) & drive_i[i].oe_n);
		end
	end
endmodule

// ===== sim/mcu_io_port_bank_bench.sv
// Self-checking testbench of the I/O port bank
`timescale 1ns/1ps
module mcu_io_port_bank_bench;
	import io_port_pkg::*;
	logic                       clock_i = 1'b0;
	logic                       srst_i  = 1'b1;
	reg_addr_t                  addr_i  = '0;
	port_byte_t                 wdata_i = '0;
	logic                       wr_i    = 1'b0;
	logic                       rd_i    = 1'b0;
	port_byte_t                 rdata_o;
	port_byte_t [NUM_PORTS-1:0] pin_in;
	port_byte_t [NUM_PORTS-1:0] ext_lvl = '0;
	pin_drive_t [NUM_PORTS-1:0] drive;
	port_byte_t                 pu0, pu1, pu4, analog;
	logic [6:0]                 periph  = '0;
	logic                       sck_drv = 1'b0;
	logic [NUM_IRQ-1:0]         irq;
	logic [7:0]                 ins;
	int                         bad_count = 0;
	int                         cmp_count = 0;
	int                         hits [NUM_IRQ];

	mcu_io_port_bank mcu_io_port_bank_i (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_in_i(pin_in),
		.pin_drive_o(drive), .port_zero_pullup_select_o(pu0), .port_one_pullup_select_o(pu1),
		.port_four_pullup_select_o(pu4), .buzzer_out_i(periph[0]), .async_tx_first_i(periph[1]),
		.async_tx_second_i(periph[2]), .sio_data_out_i(periph[3]), .sio_clock_out_i(periph[4]),
		.sio_clock_drive_i(sck_drv), .timer_three_pulse_out_i(periph[5]),
		.timer_three_compare_out_i(periph[6]), .ext_irq_req_o(irq),
		.event_count_in_zero_o(ins[0]), .event_count_in_one_o(ins[1]),
		.async_clock_in_first_o(ins[2]), .async_rx_first_o(ins[3]),
		.async_clock_in_second_o(ins[4]), .async_rx_second_o(ins[5]),
		.sio_clock_in_o(ins[6]), .sio_data_in_o(ins[7]), .analog_in_channels_o(analog));
	io_board_model io_board_model_i (.drive_i(drive), .pu0_i(pu0), .pu1_i(pu1), .pu4_i(pu4),
		.ext_i(ext_lvl), .pin_o(pin_in));

	// ----------------------------------------------------------------
	// Clock, pulse counting and shared tasks
	// ----------------------------------------------------------------
	initial begin
		forever #5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		if (!srst_i) foreach (hits[k]) hits[k] += int'(irq[k]);
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input reg_addr_t a, input port_byte_t d);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i    <= 1'b0;
	endtask
	task automatic rdchk(input reg_addr_t a, input port_byte_t exp);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i   <= 1'b0;
		#1 check("rdata", rdata_o, exp);
	endtask
	// Sets the interrupt pins, then counts request pulses per line
	task automatic edge_run(input port_byte_t v, input logic [3:0] exp);
		#1 foreach (hits[k]) hits[k] = 0;
		@(posedge clock_i);
		ext_lvl[IDX_P1] <= v;
		ext_lvl[IDX_P5] <= v;
		repeat (8) @(posedge clock_i);
		#1 foreach (hits[k]) check("irq", 8'(hits[k]), 8'(exp[k]));
	endtask
	task automatic results();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clock_i);
		bad_count++;
		results();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clock_i);
		srst_i <= 1'b0;
		#1 check("pullups", pu0 | pu1 | pu4, 8'h00);
		for (int i = 0; i < NUM_PORTS; i++) begin
			check("oe_n", drive[i].oe_n, 8'hff);
			rdchk(ADDR_DIR_BASE + 5'(i), 8'h00);
		end
		rdchk(5'h1f, 8'h00);
		// Mixed directions inside one port; bits past the width stay inputs
		for (int i = 0; i < NUM_PORTS; i++) begin
			wr(ADDR_DATA_BASE + 5'(i), 8'h3c);
			wr(ADDR_DIR_BASE + 5'(i), 8'ha5);
			rdchk(ADDR_DIR_BASE + 5'(i), 8'ha5 & PORT_MASK[i]);
			check("oe_n", drive[i].oe_n, ~(8'ha5 & PORT_MASK[i]));
			check("level", drive[i].level & ~drive[i].oe_n, 8'h24 & PORT_MASK[i]);
			rdchk(ADDR_DATA_BASE + 5'(i), 8'h24 & PORT_MASK[i]);
			wr(ADDR_DIR_BASE + 5'(i), 8'h00);
		end
		// Line 0 rise, 1 fall, 2 both, 3 both
		wr(ADDR_ALT_BASE + 5'(IDX_P1), 8'h07);
		wr(ADDR_ALT_BASE + 5'(IDX_P5), 8'h01);
		wr(ADDR_IRQ_EDGE, 8'hf9);
		edge_run(8'hff, 4'b1101);
		edge_run(8'h00, 4'b1110);
		// Peripheral outputs take the pins with direction still input
		wr(ADDR_ALT_BASE + 5'(IDX_P1), 8'h08);
		wr(ADDR_ALT_BASE + 5'(IDX_P3), 8'h08);
		wr(ADDR_ALT_BASE + 5'(IDX_P4), 8'h94);
		wr(ADDR_ALT_BASE + 5'(IDX_P5), 8'h10);
		sck_drv <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			periph <= k ? 7'h3f : 7'h40;
			@(posedge clock_i);
			#1 check("p1 oe", drive[IDX_P1].oe_n, 8'hf7);
			check("p1 lvl", drive[IDX_P1].level & 8'h08, k ? 8'h08 : 8'h00);
			check("p3 oe", drive[IDX_P3].oe_n, 8'hf7);
			check("p3 lvl", drive[IDX_P3].level & 8'h08, k ? 8'h08 : 8'h00);
			check("p4 oe", drive[IDX_P4].oe_n, 8'h6b);
			check("p4 lvl", drive[IDX_P4].level & 8'h94, k ? 8'h94 : 8'h00);
			check("p5 oe", drive[IDX_P5].oe_n, 8'hef);
			check("p5 lvl", drive[IDX_P5].level & 8'h10, k ? 8'h10 : 8'h00);
		end
		wr(ADDR_MISC, 8'h01);
		#1 check("p5 cmp", drive[IDX_P5].level & 8'h10, 8'h00);
		// External clock on the serial clock pin, and the sampling alternates
		wr(ADDR_ALT_BASE + 5'(IDX_P3), 8'h0e);
		wr(ADDR_ALT_BASE + 5'(IDX_P4), 8'hfc);
		wr(ADDR_ALT_BASE + 5'(IDX_P5), 8'h12);
		sck_drv <= 1'b0;
		ext_lvl <= {8'h00, 8'h02, 8'h6c, 8'h06, 8'h20, 8'h00};
		repeat (4) @(posedge clock_i);
		#1 check("sck oe", drive[IDX_P4].oe_n & 8'h04, 8'h04);
		check("alt in", ins, 8'hff);
		// Input bits read the pin: two from outside, one from the transmitter
		rdchk(ADDR_DATA_BASE + 5'(IDX_P3), 8'h0e);
		// Analog channels release port 6 even with direction out
		wr(ADDR_DIR_BASE + 5'(IDX_P6), 8'hff);
		wr(ADDR_ALT_BASE + 5'(IDX_P6), 8'hff);
		#1 check("analog", analog, 8'hff);
		check("p6 oe", drive[IDX_P6].oe_n, 8'hff);
		for (int i = 0; i < NUM_PU; i++) wr(ADDR_PU_BASE + 5'(i), 8'hff);
		#1 check("pu0", pu0, PORT_MASK[IDX_P0]);
		check("pu1", pu1, PORT_MASK[IDX_P1]);
		check("pu4", pu4, PORT_MASK[IDX_P4]);
		// Mid-run reset must drop pull-ups and leave port 6 released again
		@(posedge clock_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		srst_i <= 1'b0;
		#1 check("rst pu", pu0 | pu1 | pu4, 8'h00);
		check("rst oe", drive[IDX_P6].oe_n, 8'hff);
		results();
	end
endmodule
